// >>> pkg/lsm_params.svh
// offsets, field positions, reset values and timing counts of the load switch sequencer
// assumes a 50 ns clock; times are given in ns and turned into cycle counts here
`ifndef LSM_PARAMS_SVH
`define LSM_PARAMS_SVH
`define LSM_CLK_NS        50
`define LSM_TINIT_NS      100000
`define LSM_TDIS_NS       100000
`define LSM_TDEB_BUS_NS   100000
`define LSM_TDEB_OUT_NS   100000
`define LSM_TDEB_EN_NS    10000
`define LSM_TDEB_FLAG_NS  10000
// least times round up to whole cycles
`define LSM_CYC(t)        (((t) + `LSM_CLK_NS - 1) / `LSM_CLK_NS)
`define LSM_TINIT_CYC     `LSM_CYC(`LSM_TINIT_NS)
`define LSM_TDIS_CYC      `LSM_CYC(`LSM_TDIS_NS)
`define LSM_TDEB_BUS_CYC  `LSM_CYC(`LSM_TDEB_BUS_NS)
`define LSM_TDEB_OUT_CYC  `LSM_CYC(`LSM_TDEB_OUT_NS)
`define LSM_TDEB_EN_CYC   `LSM_CYC(`LSM_TDEB_EN_NS)
`define LSM_TDEB_FLAG_CYC `LSM_CYC(`LSM_TDEB_FLAG_NS)
`define LSM_ADDR_CTRL     12'h000
`define LSM_ADDR_STATUS   12'h004
`define LSM_CTRL_HOLD_BIT 0
`define LSM_CTRL_RESET    1'b0
`define LSM_ST_BUS_BIT    4
`define LSM_ST_OUT_BIT    5
`define LSM_ST_EN_BIT     6
`define LSM_ST_FLAG_BIT   7
`define LSM_ST_TEMP_BIT   8
`endif

// >>> pkg/lsm_pkg.sv
// types of the load switch mode state machine
// used together with lsm_params.svh
package lsm_pkg;
    typedef enum logic [3:0] {
        LSM_OFF       = 4'h0,
        LSM_INIT      = 4'h1,
        LSM_TSD_SLV   = 4'h2,
        LSM_TSD_AUTO  = 4'h3,
        LSM_A_READY   = 4'h4,
        LSM_A_DISCH   = 4'h5,
        LSM_A_ON      = 4'h6,
        LSM_OTG_READY = 4'h7,
        LSM_OTG_ON    = 4'h8,
        LSM_OTG_DISCH = 4'h9,
        LSM_S_READY   = 4'hA,
        LSM_S_OTG_RDY = 4'hB,
        LSM_S_ON      = 4'hC
    } lsm_state_t;

    typedef struct packed {
        logic sw_close;
        logic wdis;
        logic flag_low;
        logic disch;
    } lsm_pins_t;
endpackage

// >>> logic/lsm_top.sv
// load switch mode state machine with its AXI4-Lite control and status registers
// comparator inputs are synchronous to clk; the flag pin is open drain and resolved outside
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "lsm_params.svh"

module lsm_debounce #(
    parameter int N = 4
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic raw,
    output logic      level
);
    localparam int CW = $clog2(N + 1);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_level;

    always_comb begin
        next_cnt   = '0;
        next_level = level;
        if (raw != level) begin
            if (cnt == CW'(N - 1)) begin
                next_level = raw;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt   <= '0;
            level <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            level <= next_level;
        end
    end
endmodule

// Overview of operation
// (RL1) In init, hold switch open, both pins low, for the init time.
// (RL2) Leaving init, enable low selects autonomous mode, high selects slave mode.
// (RL3) Over-temperature in any slave state enters slave thermal shutdown, disable high.
// (RL4) Over-temperature in any autonomous state enters autonomous thermal shutdown.
// (RL5) Auto ready: switch open, pins low; re-entered from discharge on invalid bus.
// (RL6) Valid bus in auto mode: open, disable high, discharge both rails, least time.
// (RL7) Discharge exits to auto on only once output rail is below lockout, raw.
// (RL8) Auto on: switch closed, disable high, flag low; left only on power loss, over-temperature or enable high.
// (RL9) Valid output rail in auto mode: open, disable low, flag released high.
// (RL10) OTG enable detected: close switch, disable high, system holds flag low.
// (RL11) Flag released in OTG on: open, disable high, discharge, then OTG ready.
// (RL12) Slave ready: switch open, both pins low; also reached from autonomous exits.
// (RL13) Slave mode, valid output rail, enable high: open, disable low, flag released.
// (RL14) Slave mode, enable low: close switch, disable high, flag low.
// (RL15) Enable high in any autonomous state exits to a slave state.
// (RL16) Exit maps OTG ready to slave OTG ready, all others to slave ready.
// (RL17) Overvoltage only opens the switch, never changes the state.
// (RL18) Bus input valid only after staying above lockout for its debounce time.
// (RL19) Output rail valid after its debounce time, and only while bus invalid.
// (RL20) System pulls flag low only after release, for the flag debounce time.
// (RL21) Power lost on both rails forces the state machine to off.
module lsm_top
    import lsm_pkg::*;
#(
    parameter int INIT_CYC = `LSM_TINIT_CYC,
    parameter int DIS_CYC  = `LSM_TDIS_CYC,
    parameter int BUS_CYC  = `LSM_TDEB_BUS_CYC,
    parameter int OUT_CYC  = `LSM_TDEB_OUT_CYC,
    parameter int EN_CYC   = `LSM_TDEB_EN_CYC,
    parameter int FLAG_CYC = `LSM_TDEB_FLAG_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        bus_uv_ok,
    input  wire logic        out_uv_ok,
    input  wire logic        over_temp,
    input  wire logic        over_voltage,
    input  wire logic        enable_n,
    input  wire logic        flag_in,
    output logic             flag_o,
    output logic             flag_oe,
    output logic             switch_close,
    output logic             wireless_dis,
    output logic             discharge_en,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int MAXC = (INIT_CYC > DIS_CYC) ? INIT_CYC : DIS_CYC;
    localparam int TW   = $clog2(MAXC + 1);

    if (INIT_CYC < 1 || DIS_CYC < 1 || BUS_CYC < 1 || OUT_CYC < 1 || EN_CYC < 1
        || FLAG_CYC < 1) begin : g_bad_param
        $error("lsm_top: every cycle count must be at least one");
    end

    lsm_state_t    state;
    lsm_state_t    next_state;
    logic [TW-1:0] tmr;
    logic [TW-1:0] next_tmr;
    lsm_pins_t     pins;
    logic          hold_open;
    logic          next_hold_open;
    logic          power_ok;
    logic          bus_valid;
    logic          out_deb;
    logic          out_valid;
    logic          en_n_deb;
    logic          flag_deb;
    logic          auto_st;
    logic          slave_st;

    assign power_ok  = bus_uv_ok | out_uv_ok;
    assign out_valid = out_deb & ~bus_valid; // RL19

    lsm_debounce #(.N(BUS_CYC)) u_deb_bus (
        .clk(clk), .rst_b(rst_b), .raw(bus_uv_ok), .level(bus_valid)); // RL18
    lsm_debounce #(.N(OUT_CYC)) u_deb_out (
        .clk(clk), .rst_b(rst_b), .raw(out_uv_ok & ~bus_valid), .level(out_deb)); // RL19
    lsm_debounce #(.N(EN_CYC)) u_deb_en (
        .clk(clk), .rst_b(rst_b), .raw(enable_n), .level(en_n_deb));
    // flag only counts as forced low while the device has it released
    lsm_debounce #(.N(FLAG_CYC)) u_deb_flag (
        .clk(clk), .rst_b(rst_b), .raw(flag_in | flag_oe), .level(flag_deb)); // RL20

    always_comb begin
        auto_st  = 1'b0;
        slave_st = 1'b0;
        case (state)
            LSM_A_READY, LSM_A_DISCH, LSM_A_ON,
            LSM_OTG_READY, LSM_OTG_ON, LSM_OTG_DISCH: auto_st = 1'b1;
            LSM_S_READY, LSM_S_OTG_RDY, LSM_S_ON:     slave_st = 1'b1;
            default: ;
        endcase
    end

    always_comb begin
        next_state = state;
        if (!power_ok) begin
            next_state = LSM_OFF; // RL21
        end else if (slave_st && over_temp) begin
            next_state = LSM_TSD_SLV; // RL3
        end else if (auto_st && over_temp) begin
            next_state = LSM_TSD_AUTO; // RL4
        end else if (auto_st && en_n_deb) begin
            // RL15 RL16
            next_state = (state == LSM_OTG_READY) ? LSM_S_OTG_RDY : LSM_S_READY;
        end else begin
            case (state)
                LSM_OFF: next_state = LSM_INIT;
                LSM_INIT: begin
                    if (tmr >= TW'(INIT_CYC)) begin
                        next_state = en_n_deb ? LSM_S_READY : LSM_A_READY; // RL2
                    end
                end
                LSM_TSD_SLV:  if (!over_temp) next_state = LSM_S_READY;
                LSM_TSD_AUTO: if (!over_temp) next_state = LSM_A_READY;
                LSM_A_READY: begin
                    if (bus_valid) begin
                        next_state = LSM_A_DISCH; // RL6
                    end else if (out_valid) begin
                        next_state = LSM_OTG_READY; // RL9
                    end
                end
                LSM_A_DISCH: begin
                    if (!bus_valid) begin
                        next_state = LSM_A_READY; // RL5
                    end else if (tmr >= TW'(DIS_CYC) && !out_uv_ok) begin
                        next_state = LSM_A_ON; // RL7
                    end
                end
                LSM_A_ON: next_state = LSM_A_ON; // RL8
                LSM_OTG_READY: begin
                    if (bus_valid) begin
                        next_state = LSM_A_DISCH;
                    end else if (!out_valid) begin
                        next_state = LSM_A_READY;
                    end else if (!flag_deb) begin
                        next_state = LSM_OTG_ON; // RL10
                    end
                end
                LSM_OTG_ON:    if (flag_deb) next_state = LSM_OTG_DISCH; // RL11
                LSM_OTG_DISCH: if (tmr >= TW'(DIS_CYC)) next_state = LSM_OTG_READY; // RL11
                LSM_S_READY: begin
                    if (!en_n_deb) begin
                        next_state = LSM_S_ON; // RL14
                    end else if (out_valid) begin
                        next_state = LSM_S_OTG_RDY; // RL13
                    end
                end
                LSM_S_OTG_RDY: begin
                    if (!en_n_deb) begin
                        next_state = LSM_S_ON;
                    end else if (!out_valid) begin
                        next_state = LSM_S_READY;
                    end
                end
                LSM_S_ON: if (en_n_deb) next_state = LSM_S_READY;
                default:  next_state = LSM_OFF;
            endcase
        end
        next_tmr = (next_state != state) ? '0 : ((tmr == TW'(MAXC)) ? tmr : tmr + 1'b1);
    end

    // pin pattern of each state, decoded from next_state so the pins register together with the state
    always_comb begin
        pins = '{sw_close: 1'b0, wdis: 1'b0, flag_low: 1'b1, disch: 1'b0}; // RL1 RL5 RL12
        case (next_state)
            LSM_TSD_SLV, LSM_TSD_AUTO: pins.wdis = 1'b1; // RL3 RL4
            LSM_A_DISCH: begin
                pins.wdis  = 1'b1; // RL6
                pins.disch = 1'b1;
            end
            LSM_A_ON, LSM_S_ON: begin
                pins.sw_close = 1'b1; // RL8 RL14
                pins.wdis     = 1'b1;
            end
            LSM_OTG_READY, LSM_S_OTG_RDY: pins.flag_low = 1'b0; // RL9 RL13
            LSM_OTG_ON: begin
                pins.sw_close = 1'b1; // RL10
                pins.wdis     = 1'b1;
                pins.flag_low = 1'b0;
            end
            LSM_OTG_DISCH: begin
                pins.wdis     = 1'b1; // RL11
                pins.flag_low = 1'b0;
                pins.disch    = 1'b1;
            end
            default: ;
        endcase
        // overvoltage gates the switch only; the state goes on unchanged
        if (over_voltage || hold_open) begin
            pins.sw_close = 1'b0; // RL17
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= LSM_OFF;
            tmr          <= '0;
            switch_close <= 1'b0;
            wireless_dis <= 1'b0;
            flag_oe      <= 1'b1;
            flag_o       <= 1'b0;
            discharge_en <= 1'b0;
        end else begin
            state        <= next_state;
            tmr          <= next_tmr;
            switch_close <= pins.sw_close;
            wireless_dis <= pins.wdis;
            flag_oe      <= pins.flag_low;
            flag_o       <= 1'b0;
            discharge_en <= pins.disch;
        end
    end

    // AXI4-Lite slave: address and data are taken together, one access of each kind at a time
    logic        wr_go;
    logic        rd_go;
    logic        next_awready;
    logic        next_arready;
    logic        next_bvalid;
    logic        next_rvalid;
    logic [1:0]  next_bresp;
    logic [1:0]  next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] status_word;

    assign wr_go = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    assign rd_go = s_axi_arready & s_axi_arvalid;

    always_comb begin
        status_word                     = {28'h0000000, state};
        status_word[`LSM_ST_BUS_BIT]    = bus_valid;
        status_word[`LSM_ST_OUT_BIT]    = out_valid;
        status_word[`LSM_ST_EN_BIT]     = en_n_deb;
        status_word[`LSM_ST_FLAG_BIT]   = flag_deb;
        status_word[`LSM_ST_TEMP_BIT]   = over_temp;
        next_hold_open = hold_open;
        next_bresp     = s_axi_bresp;
        next_bvalid    = s_axi_bvalid & ~s_axi_bready;
        next_awready   = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp  = 2'h0;
            if (s_axi_awaddr == `LSM_ADDR_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    next_hold_open = s_axi_wdata[`LSM_CTRL_HOLD_BIT];
                end
            end else if (s_axi_awaddr != `LSM_ADDR_STATUS) begin
                next_bresp = 2'h2;
            end
        end
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        next_rvalid  = s_axi_rvalid & ~s_axi_rready;
        next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp  = 2'h0;
            if (s_axi_araddr == `LSM_ADDR_CTRL) begin
                next_rdata = {31'h00000000, hold_open};
            end else if (s_axi_araddr == `LSM_ADDR_STATUS) begin
                next_rdata = status_word;
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = 2'h2;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_open     <= `LSM_CTRL_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            hold_open     <= next_hold_open;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_awready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_disch_to_on;
        state == LSM_A_DISCH ##1 state == LSM_A_ON;
    endsequence

    a_off_on_loss: assert property (!power_ok |=> state == LSM_OFF) // RL21
        else $error("state not off after loss of power");
    a_init_pins: assert property (state == LSM_INIT && power_ok && !over_voltage
        |=> !switch_close && !wireless_dis && flag_oe) // RL1
        else $error("init pins wrong");
    a_init_choice: assert property (state == LSM_INIT && next_state != LSM_INIT && power_ok
        |=> state == ($past(en_n_deb) ? LSM_S_READY : LSM_A_READY)) // RL2
        else $error("wrong mode chosen after init");
    a_tsd_slave: assert property (slave_st && over_temp && power_ok
        |=> state == LSM_TSD_SLV && wireless_dis && !switch_close) // RL3
        else $error("slave thermal shutdown missed");
    a_tsd_auto: assert property (auto_st && over_temp && power_ok
        |=> state == LSM_TSD_AUTO) // RL4
        else $error("auto thermal shutdown missed");
    a_disch_safe: assert property (s_disch_to_on |-> $past(!out_uv_ok) && $past(tmr) >= TW'(DIS_CYC)) // RL7
        else $error("left discharge with output rail up");
    a_auto_on_pins: assert property (state == LSM_A_ON && power_ok && !over_temp
        && !en_n_deb && !over_voltage && !hold_open
        |=> switch_close && wireless_dis && flag_oe) // RL8
        else $error("auto on pins wrong");
    a_exit_map: assert property (state == LSM_OTG_READY && en_n_deb && power_ok && !over_temp
        |=> state == LSM_S_OTG_RDY) // RL16
        else $error("exit mapping wrong");
    a_ovp_open: assert property (over_voltage |=> !switch_close && state == $past(next_state)) // RL17
        else $error("overvoltage did not open switch");
endmodule

// >>> tb/lsm_sys_model.sv
// system controller side of the handshake pin, with the pin's pull-up
// assumes the device's flag_o/flag_oe; otg_req comes from the bench
`timescale 1ns/1ns
module lsm_sys_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic flag_o,
    input  wire logic flag_oe,
    input  wire logic otg_req,
    output logic      flag_in
);
    logic pulling;

    // the system only pulls once the device has let go of the pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pulling <= 1'b0;
        end else if (!otg_req) begin
            pulling <= 1'b0;
        end else if (!flag_oe) begin
            pulling <= 1'b1;
        end
    end

    // open-drain wire: low if either party pulls, else the pull-up wins
    assign flag_in = !(flag_oe && !flag_o) && !pulling;
endmodule

// >>> tb/tb.sv
// self-checking bench of the load switch mode state machine
// assumes lsm_top with short counts and the system model on the pin
`timescale 1ns/1ns
module tb;
    import lsm_pkg::*;
    localparam int DIS = 8;
    logic        clk = 1'b0, rst_b = 1'b0, bus_uv_ok = 1'b0, out_uv_ok = 1'b0;
    logic        over_temp = 1'b0, over_voltage = 1'b0, enable_n = 1'b0, otg_req = 1'b0;
    logic        flag_in, flag_o, flag_oe, switch_close, wireless_dis, discharge_en;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] rnd = 32'h0001_30B6;
    logic [31:0] rdat;
    int          err_count = 0;
    int          compares = 0;

    always #25 clk = ~clk;

    lsm_top #(.INIT_CYC(8), .DIS_CYC(DIS), .BUS_CYC(4), .OUT_CYC(4), .EN_CYC(2),
              .FLAG_CYC(2)) i_dut (
        .clk, .rst_b, .bus_uv_ok, .out_uv_ok, .over_temp, .over_voltage, .enable_n,
        .flag_in, .flag_o, .flag_oe, .switch_close, .wireless_dis, .discharge_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    lsm_sys_model i_sys (.clk, .rst_b, .flag_o, .flag_oe, .otg_req, .flag_in);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // switch, receiver disable, flag pulled low, discharge for each state
    function automatic lsm_pins_t exp_pins(input lsm_state_t s);
        case (s)
            LSM_TSD_SLV, LSM_TSD_AUTO:    return 4'b0110;
            LSM_A_DISCH:                  return 4'b0111;
            LSM_A_ON, LSM_S_ON:           return 4'b1110;
            LSM_OTG_READY, LSM_S_OTG_RDY: return 4'b0000;
            LSM_OTG_ON:                   return 4'b1100;
            LSM_OTG_DISCH:                return 4'b0101;
            default:                      return 4'b0010;
        endcase
    endfunction

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pins(input lsm_pins_t e);
        chk_val(32'({switch_close, wireless_dis, flag_oe, discharge_en}), 32'(e), "pins");
        chk_val(32'(flag_o), 32'h0, "flag drive value");
    endtask

    // one access; each channel released at its own handshake
    task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_araddr  <= a;
        s_axi_awvalid <= wr;
        s_axi_wvalid  <= wr;
        s_axi_bready  <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready  <= !wr;
        while (!done && n < 40) begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (wr ? s_axi_bvalid : s_axi_rvalid) begin
                resp = wr ? s_axi_bresp : s_axi_rresp;
                rdat = s_axi_rdata;
                done = 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        chk_val(32'(done), 32'h1, "bus answer");
        @(posedge clk);
    endtask

    // polls the status word until the state shows, then checks the pins
    task automatic expect_state(input lsm_state_t s);
        int n;
        n = 0;
        do begin
            axi(1'b0, 12'h004, 32'h0);
            n++;
        end while (rdat[3:0] !== s && n < 60);
        chk_val(32'(rdat[3:0]), 32'(s), "state");
        chk_pins(exp_pins(s));
    endtask

    task automatic wait_pin(input logic wd, input logic ds);
        int n;
        n = 0;
        while (!(wireless_dis === wd && discharge_en === ds) && n < 100) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic power_off;
        bus_uv_ok <= 1'b0;
        out_uv_ok <= 1'b0;
        expect_state(LSM_OFF);
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end

    initial begin
        int n;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        enable_n  <= 1'b1;
        bus_uv_ok <= 1'b1;
        axi(1'b0, 12'h004, 32'h0);
        chk_val(32'(rdat[3:0]), 32'(LSM_INIT), "init state");
        chk_pins(exp_pins(LSM_INIT));
        expect_state(LSM_S_READY);
        enable_n <= 1'b0;
        expect_state(LSM_S_ON);
        over_temp <= 1'b1;
        expect_state(LSM_TSD_SLV);
        over_temp <= 1'b0;
        power_off;
        $display("test slave start done at %0t", $time);

        out_uv_ok <= 1'b1;
        bus_uv_ok <= 1'b1;
        expect_state(LSM_A_DISCH);
        rnd = lfsr(rnd);
        // output rail still up, so discharge must not finish however long it runs
        repeat (DIS + rnd[2:0]) @(posedge clk);
        expect_state(LSM_A_DISCH);
        bus_uv_ok <= 1'b0;
        wait_pin(1'b0, 1'b0);
        chk_pins(exp_pins(LSM_A_READY));
        expect_state(LSM_OTG_READY);
        otg_req <= 1'b1;
        expect_state(LSM_OTG_ON);
        otg_req <= 1'b0;
        wait_pin(1'b1, 1'b1);
        chk_pins(exp_pins(LSM_OTG_DISCH));
        n = 0;
        while (discharge_en === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk_val(32'(n >= DIS - 1), 32'h1, "discharge length");
        expect_state(LSM_OTG_READY);
        bus_uv_ok <= 1'b1;
        expect_state(LSM_A_DISCH);
        out_uv_ok <= 1'b0;
        expect_state(LSM_A_ON);
        axi(1'b1, 12'h000, 32'h0000_0001);
        chk_val(32'(switch_close), 32'h0, "hold open");
        axi(1'b0, 12'h000, 32'h0);
        chk_val(rdat, 32'h0000_0001, "control readback");
        axi(1'b1, 12'h000, 32'h0000_0000);
        rnd = lfsr(rnd);
        axi(1'b1, 12'h004, rnd);
        chk_val(32'(resp), 32'h0, "status write response");
        axi(1'b1, 12'h010, rnd);
        chk_val(32'(resp), 32'h2, "unmapped write response");
        axi(1'b0, 12'h010, 32'h0);
        chk_val(32'(resp), 32'h2, "unmapped read response");
        chk_val(rdat, 32'h0, "unmapped read data");
        over_voltage <= 1'b1;
        repeat (2) @(posedge clk);
        chk_val(32'(switch_close), 32'h0, "overvoltage opens");
        over_voltage <= 1'b0;
        expect_state(LSM_A_ON);
        over_temp <= 1'b1;
        expect_state(LSM_TSD_AUTO);
        over_temp <= 1'b0;
        expect_state(LSM_A_ON);
        enable_n <= 1'b1;
        expect_state(LSM_S_READY);
        power_off;
        $display("test autonomous done at %0t", $time);

        enable_n  <= 1'b0;
        out_uv_ok <= 1'b1;
        expect_state(LSM_OTG_READY);
        enable_n <= 1'b1;
        expect_state(LSM_S_OTG_RDY);
        power_off;
        $display("test slave exit done at %0t", $time);
        test_done;
    end
endmodule
